// ### dv/mia_core_model.sv
// core sequencer model: clears the served flag, then returns
`timescale 1ns/100ps
module mia_core_model
	import mia_pkg::*;
(
	input  wire logic	ref_clk,
	input  wire logic	rstn,
	input  wire mia_svc_t	svc,
	output logic		flagClrWr,
	output logic [14:0]	flagClrData,
	output logic		returnFromInterruptOp
);
	// random handler time so prompt and slow returns both occur
	initial begin
		flagClrWr = 1'b0;
		flagClrData = '0;
		returnFromInterruptOp = 1'b0;
		forever begin
			@(negedge ref_clk);
			if (rstn === 1'b1 && svc.active === 1'b1) begin
				repeat ($urandom_range(3)) @(negedge ref_clk);
				flagClrWr = 1'b1;
				flagClrData = (svc.srcId < 5'h0F) ? 15'h0001 << svc.srcId : '0;
				@(negedge ref_clk);
				flagClrWr = 1'b0;
				returnFromInterruptOp = 1'b1;
				@(negedge ref_clk);
				returnFromInterruptOp = 1'b0;
				// service ends one cycle after the return is taken
				repeat (2) @(negedge ref_clk);
			end
		end
	end
endmodule

// ### dv/tb_top.sv
// self-checking bench for the maskable interrupt arbiter
`timescale 1ns/100ps
module tb_top;
	import mia_pkg::*;
	logic		ref_clk, rstn, extReqN, extLevelMode, flagClrWr, elevWr;
	logic		setGlobalMask, clrGlobalMask, returnFromInterruptOp, tableWrReq;
	logic		nonvolatileWriteProtect, globalMask_r, saveState_r, restoreState_r;
	logic		tableWrOk_r, lastAct, lastSave, lastRest;
	logic [14:0]	eventIn, localMask, flagClrData, flags_r, p;
	logic [3:0]	elevData, el;
	logic [4:0]	nmiIn, e;
	logic [15:0]	tableWrAddr;
	mia_svc_t	svc_r;
	logic [4:0]	expQ[$];
	int		err_total, n_checks, k, r;
	logic [15:0]	ta[6] = '{16'hAE1F, 16'hAE20, 16'hAEBF, 16'hAEC0, 16'hAE80, 16'hAE20};
	logic [5:0]	tok = 6'h06;
	logic [5:0]	twp = 6'h30;

	mia_arbiter mia_arbiter_inst (.ref_clk, .rstn, .eventIn, .localMask, .extReqN,
		.extLevelMode, .flagClrWr, .flagClrData, .elevWr, .elevData, .nmiIn,
		.setGlobalMask, .clrGlobalMask, .returnFromInterruptOp, .tableWrReq,
		.tableWrAddr, .nonvolatileWriteProtect, .flags_r, .globalMask_r,
		.saveState_r, .restoreState_r, .svc_r, .tableWrOk_r);
	mia_core_model mia_core_model_inst (.ref_clk, .rstn, .svc(svc_r), .flagClrWr,
		.flagClrData, .returnFromInterruptOp);

	////////////////////////////////////////////////////////////////////////////////
	// clock, 50 ns period
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		n_checks++;
		if (got !== ex) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", nm, ex, got);
		end
	endtask

	task automatic end_sim;
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// open the global mask, wait for all noted services, close it again
	task automatic drain(input bit doClr);
		int t;
		clrGlobalMask = doClr;
		@(negedge ref_clk);
		clrGlobalMask = 1'b0;
		t = 0;
		while ((expQ.size() > 0 || svc_r.active !== 1'b0) && t < 500) begin
			@(negedge ref_clk);
			t++;
		end
		if (t >= 500) begin
			err_total++;
			end_sim();
		end
		repeat (4) @(negedge ref_clk);
		setGlobalMask = 1'b1;
		@(negedge ref_clk);
		setGlobalMask = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watcher: each new service is matched against the oldest note
	always @(negedge ref_clk) begin
		if (rstn) begin
			if (svc_r.active === 1'b1 && !lastAct) begin
				e = expQ.size() ? expQ.pop_front() : 5'h1F;
				chk("saveState", 16'h0001, {15'h0, lastSave});
				chk("globalMask", 16'h0001, {15'h0, globalMask_r});
				chk("srcId", {11'h0, e}, {11'h0, svc_r.srcId});
				chk("vecAddr", MIA_TBL_BASE + (16'(e) << 3), svc_r.vecAddr);
			end
			// a service may only end through a restore pulse
			if (svc_r.active === 1'b0 && lastAct === 1'b1)
				chk("restoreState", 16'h0001, {15'h0, lastRest});
			if (lastRest)
				chk("globalMask", 16'h0000, {15'h0, globalMask_r});
		end
		lastAct = svc_r.active;
		lastSave = saveState_r;
		lastRest = restoreState_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence, inputs change on the falling edge
	initial begin
		void'($urandom(32'h57E02B3A));
		{rstn, extLevelMode, elevWr, setGlobalMask, clrGlobalMask} = '0;
		{tableWrReq, nonvolatileWriteProtect, lastAct, lastSave, lastRest} = '0;
		{eventIn, localMask, elevData, nmiIn, tableWrAddr} = '0;
		extReqN = 1'b1;
		repeat (16) @(negedge ref_clk);
		rstn = 1'b1;
		chk("globalMask", 16'h0001, {15'h0, globalMask_r});
		chk("flags", 16'h0000, {1'b0, flags_r});
		// flags rise unmasked; only the masked-in one is served
		eventIn = 15'h0028;
		@(negedge ref_clk);
		eventIn = '0;
		@(negedge ref_clk);
		chk("flags", 16'h0028, {1'b0, flags_r});
		localMask = 15'h0008;
		expQ.push_back(5'h03);
		repeat (4) @(negedge ref_clk);
		drain(1'b1);
		chk("flags", 16'h0020, {1'b0, flags_r});
		// events arrive lowest priority first, served highest first;
		// masks go up before the new events, the one stale flag is expected
		localMask = 15'h7FFF;
		for (r = 0; r < 3; r++) begin
			p = 15'($urandom) & 15'h7FFE | 15'h0020;
			for (k = 14; k > 0; k--) begin
				eventIn = p & (15'h0001 << k);
				@(negedge ref_clk);
			end
			eventIn = '0;
			extReqN = 1'b0;
			@(negedge ref_clk);
			extReqN = 1'b1;
			expQ.push_back(5'(MIA_SRC_EXTREQ));
			for (k = 1; k < 15; k++)
				if (p[k])
					expQ.push_back(5'(k));
			drain(1'b1);
		end
		// one elevated source, then none elevated
		for (r = 0; r < 2; r++) begin
			el = r ? 4'hF : 4'(1 + $urandom_range(13));
			elevWr = 1'b1;
			elevData = el;
			@(negedge ref_clk);
			elevWr = 1'b0;
			eventIn = 15'h7FFE;
			extReqN = 1'b0;
			@(negedge ref_clk);
			eventIn = '0;
			extReqN = 1'b1;
			if (r == 0)
				expQ.push_back(5'(el));
			for (k = 0; k < 15; k++)
				if (k != el)
					expQ.push_back(5'(k));
			drain(1'b1);
		end
		// level mode: the external flag follows the pin, no latching
		extLevelMode = 1'b1;
		extReqN = 1'b0;
		@(negedge ref_clk);
		chk("extLevel", 16'h0001, {1'b0, flags_r});
		extReqN = 1'b1;
		@(negedge ref_clk);
		chk("extLevel", 16'h0000, {1'b0, flags_r});
		extLevelMode = 1'b0;
		// every nonmaskable source, global mask open and closed
		for (k = 0; k < 5; k++) begin
			clrGlobalMask = ~k[0];
			@(negedge ref_clk);
			clrGlobalMask = 1'b0;
			eventIn = 15'h0080;
			nmiIn = 5'h01 << k;
			expQ.push_back(MIA_NMI_ID_BASE + 5'(k));
			expQ.push_back(5'h07);
			@(negedge ref_clk);
			eventIn = '0;
			nmiIn = '0;
			drain(1'b0);
		end
		// dispatch table writes: range edges and protection
		for (k = 0; k < 6; k++) begin
			tableWrReq = 1'b1;
			tableWrAddr = ta[k];
			nonvolatileWriteProtect = twp[k];
			@(negedge ref_clk);
			chk("tableWrOk", {15'h0, tok[k]}, {15'h0, tableWrOk_r});
		end
		tableWrReq = 1'b0;
		end_sim();
	end
endmodule

// ### pkg/mia_pkg.sv
// constants and carrier types for the maskable interrupt arbiter
package mia_pkg;
	// maskable sources, index 0 has the highest fixed priority
	localparam int MIA_NUM_MASK = 15;
	localparam logic [3:0] MIA_SRC_EXTREQ = 4'h0;
	localparam logic [3:0] MIA_SRC_RTTICK = 4'h1;
	localparam logic [3:0] MIA_SRC_ICAP1  = 4'h2;
	localparam logic [3:0] MIA_SRC_ICAP2  = 4'h3;
	localparam logic [3:0] MIA_SRC_ICAP3  = 4'h4;
	localparam logic [3:0] MIA_SRC_OCMP1  = 4'h5;
	localparam logic [3:0] MIA_SRC_OCMP2  = 4'h6;
	localparam logic [3:0] MIA_SRC_OCMP3  = 4'h7;
	localparam logic [3:0] MIA_SRC_OCMP4  = 4'h8;
	localparam logic [3:0] MIA_SRC_IC4OC5 = 4'h9;
	localparam logic [3:0] MIA_SRC_TMROVF = 4'hA;
	localparam logic [3:0] MIA_SRC_PAOVF  = 4'hB;
	localparam logic [3:0] MIA_SRC_PAEDGE = 4'hC;
	localparam logic [3:0] MIA_SRC_SERPER = 4'hD;
	localparam logic [3:0] MIA_SRC_SERCOM = 4'hE;
	// nonmaskable sources, index 4 has the highest priority
	localparam int MIA_NUM_NMI = 5;
	localparam int MIA_NMI_PSEUDO = 0;
	localparam int MIA_NMI_SWTRAP = 1;
	localparam int MIA_NMI_ILLOP  = 2;
	localparam int MIA_NMI_WDOG   = 3;
	localparam int MIA_NMI_CLKMON = 4;
	// source id of a nonmaskable source is its index plus this base
	localparam logic [4:0] MIA_NMI_ID_BASE = 5'h0F;
	// dispatch table in nonvolatile memory, eight bytes per source
	localparam logic [15:0] MIA_TBL_BASE = 16'hAE20;
	localparam logic [15:0] MIA_TBL_LAST = 16'hAEBF;
	localparam int MIA_TBL_SHIFT = 3;
	// reset values
	localparam logic MIA_GMASK_RST = 1'b1;
	localparam logic [3:0] MIA_ELEV_RST = MIA_SRC_EXTREQ;

	// service request presented to the core sequencer
	typedef struct packed {
		logic        active;
		logic [4:0]  srcId;
		logic [15:0] vecAddr;
	} mia_svc_t;
endpackage

// ### rtl/mia_arbiter.sv
// interrupt recognition, arbitration and service sequencing
// Notes on behaviour
// - a maskable source counts only while its flag and local mask are both set; the external request has no local mask and counts on its flag alone
// - a recognized maskable source is serviced only with the global mask clear
// - pending requests are taken in priority order, not arrival order
// - fixed maskable priority, one selectable source may be raised to the top
// - nonmaskable requests outrank all maskable ones and are taken at once
// - entering service saves state, then sets the global mask
// - return restores state, clears the global mask, then next request or resume
// - vectors point into a protectable dispatch table at AE20 to AEBF
// - fifteen maskable and five nonmaskable sources are provided
// - a one-hot flag write clears only the flagged bits
// - after reset the external request is the top maskable source
`timescale 1ns/100ps
module mia_arbiter
	import mia_pkg::*;
#(
	parameter int N = MIA_NUM_MASK
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic [N-1:0]           eventIn,
	input  wire logic [N-1:0]           localMask,
	input  wire logic                   extReqN,
	input  wire logic                   extLevelMode,
	input  wire logic                   flagClrWr,
	input  wire logic [N-1:0]           flagClrData,
	input  wire logic                   elevWr,
	input  wire logic [3:0]             elevData,
	input  wire logic [MIA_NUM_NMI-1:0] nmiIn,
	input  wire logic                   setGlobalMask,
	input  wire logic                   clrGlobalMask,
	input  wire logic                   returnFromInterruptOp,
	input  wire logic                   tableWrReq,
	input  wire logic [15:0]            tableWrAddr,
	input  wire logic                   nonvolatileWriteProtect,
	output logic [N-1:0]                flags_r,
	output logic                        globalMask_r,
	output logic                        saveState_r,
	output logic                        restoreState_r,
	output mia_svc_t                    svc_r,
	output logic                        tableWrOk_r
);
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_SAVE    = 4'h2,
		ST_SERVE   = 4'h4,
		ST_RESTORE = 4'h8
	} mia_state_t;

	mia_state_t state_r;
	mia_state_t state_nxt;
	logic [MIA_NUM_NMI-1:0] nmiPend_r;
	logic [3:0]             elevSel_r;
	logic                   extReqNDly_r;
	logic [N-1:0]           recognized;
	logic [N-1:0]           effMask;
	logic                   maskValid;
	logic [3:0]             maskIdx;
	logic                   nmiValid;
	logic [4:0]             nmiId;
	logic                   takeMask;
	logic                   takeNmi;
	logic [4:0]             pickId;
	logic [4:0]             pendId_r;

	// table slot of a source; eight bytes each fill the table exactly
	function automatic logic [15:0] slotAddr(input logic [4:0] id);
		slotAddr = MIA_TBL_BASE + (16'(id) << MIA_TBL_SHIFT);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// recognition
	// the external request has no local mask, so its mask bit is forced on
	always_comb begin
		effMask = localMask;
		effMask[MIA_SRC_EXTREQ] = 1'b1;
	end
	assign recognized = flags_r & effMask;

	mia_prio_pick #(
		.N(N)
	) u_pick (
		.reqIn    (recognized),
		.elevSel  (elevSel_r),
		.pickValid(maskValid),
		.pickIdx  (maskIdx)
	);

	// highest index wins among nonmaskable requests
	always_comb begin
		nmiValid = 1'b0;
		nmiId = 5'h00;
		for (int j = 0; j < MIA_NUM_NMI; j++) begin
			if (nmiPend_r[j]) begin
				nmiValid = 1'b1;
				nmiId = MIA_NMI_ID_BASE + 5'(j);
			end
		end
	end

	// nonmaskable ignores the global mask and may nest into a service
	assign takeNmi = nmiValid && ((state_r == ST_IDLE) || (state_r == ST_SERVE));
	assign takeMask = !takeNmi && maskValid && !globalMask_r && (state_r == ST_IDLE);
	assign pickId = takeNmi ? nmiId : {1'b0, maskIdx};

	////////////////////////////////////////////////////////////////////////
	// flags: a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			flags_r <= '0;
			extReqNDly_r <= 1'b1;
		end else begin
			extReqNDly_r <= extReqN;
			for (int k = 0; k < N; k++) begin
				if (eventIn[k]) begin
					flags_r[k] <= 1'b1;
				end else if (flagClrWr && flagClrData[k]) begin
					flags_r[k] <= 1'b0;
				end
			end
			// the external request latches a falling edge or follows the level
			if (extLevelMode) begin
				flags_r[MIA_SRC_EXTREQ] <= !extReqN;
			end else if (extReqNDly_r && !extReqN) begin
				flags_r[MIA_SRC_EXTREQ] <= 1'b1;
			end else if (takeMask && (maskIdx == MIA_SRC_EXTREQ)) begin
				flags_r[MIA_SRC_EXTREQ] <= 1'b0;
			end
		end
	end

	// nonmaskable pending bits drop when their service is taken
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			nmiPend_r <= '0;
		end else begin
			for (int m = 0; m < MIA_NUM_NMI; m++) begin
				if (nmiIn[m]) begin
					nmiPend_r[m] <= 1'b1;
				end else if (takeNmi && (nmiId == MIA_NMI_ID_BASE + 5'(m))) begin
					nmiPend_r[m] <= 1'b0;
				end
			end
		end
	end

	// elevation select; out-of-range values leave the fixed order alone
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			elevSel_r <= MIA_ELEV_RST;
		end else if (elevWr) begin
			elevSel_r <= elevData;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// service sequence
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (takeNmi || takeMask) begin
					state_nxt = ST_SAVE;
				end
			end
			ST_SAVE: begin
				state_nxt = ST_SERVE;
			end
			ST_SERVE: begin
				if (takeNmi) begin
					state_nxt = ST_SAVE;
				end else if (returnFromInterruptOp) begin
					state_nxt = ST_RESTORE;
				end
			end
			ST_RESTORE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			pendId_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			if (takeNmi || takeMask) begin
				pendId_r <= pickId;
			end
		end
	end

	// state is saved one cycle before the mask goes up
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			saveState_r <= 1'b0;
			restoreState_r <= 1'b0;
		end else begin
			saveState_r <= (state_nxt == ST_SAVE);
			restoreState_r <= (state_r == ST_SERVE) && !takeNmi && returnFromInterruptOp;
		end
	end

	// global mask: reset sets it, service sets it, return clears it
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			globalMask_r <= MIA_GMASK_RST;
		end else if (state_r == ST_SAVE) begin
			globalMask_r <= 1'b1;
		end else if (restoreState_r) begin
			globalMask_r <= 1'b0;
		end else if (setGlobalMask) begin
			globalMask_r <= 1'b1;
		end else if (clrGlobalMask) begin
			globalMask_r <= 1'b0;
		end
	end

	// dispatch request to the core, held for the whole service
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			svc_r <= '0;
		end else if (state_r == ST_SAVE) begin
			svc_r.active <= 1'b1;
			svc_r.srcId <= pendId_r;
			svc_r.vecAddr <= slotAddr(pendId_r);
		end else if (restoreState_r) begin
			svc_r.active <= 1'b0;
		end
	end

	// table writes are refused while protected or outside the table
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tableWrOk_r <= 1'b0;
		end else begin
			tableWrOk_r <= tableWrReq && !nonvolatileWriteProtect &&
				(tableWrAddr >= MIA_TBL_BASE) && (tableWrAddr <= MIA_TBL_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_enter;
		saveState_r ##1 (state_r == ST_SERVE) && globalMask_r;
	endsequence
	sequence s_leave;
		restoreState_r ##1 !globalMask_r && (state_r == ST_IDLE);
	endsequence

	property p_recog;
		takeMask |-> flags_r[maskIdx] && effMask[maskIdx];
	endproperty
	a_recog: assert property (p_recog) else $error("unrecognized source taken");

	// with the mask up and no nonmaskable request, no entry may start
	property p_gmask;
		globalMask_r && (state_r == ST_IDLE) && !nmiValid |=> !saveState_r;
	endproperty
	a_gmask: assert property (p_gmask) else $error("maskable taken under mask");

	property p_prio;
		takeMask && (maskIdx != elevSel_r) |-> ((recognized & ((15'h0001 << maskIdx) - 15'h0001)) == '0);
	endproperty
	a_prio: assert property (p_prio) else $error("lower priority taken first");

	property p_nmi;
		nmiValid && state_r == ST_IDLE |=> saveState_r;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nonmaskable not taken");

	property p_enter;
		(state_r == ST_IDLE) && (takeMask || takeNmi) |=> s_enter;
	endproperty
	a_enter: assert property (p_enter) else $error("service entry order wrong");

	property p_leave;
		(state_r == ST_SERVE) && returnFromInterruptOp && !takeNmi |=> s_leave;
	endproperty
	a_leave: assert property (p_leave) else $error("return sequence wrong");

	property p_vec;
		$rose(svc_r.active) |-> svc_r.vecAddr == MIA_TBL_BASE + (16'(svc_r.srcId) << 3);
	endproperty
	a_vec: assert property (p_vec) else $error("vector address wrong");

	property p_clr;
		flagClrWr && !(|eventIn) && !extLevelMode && extReqNDly_r |=>
			((flags_r & $past(flagClrData)) & 15'h7FFE) == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("flag clear failed");

	property p_keep;
		flagClrWr && !(|eventIn) && !takeMask |=>
			((flags_r ^ $past(flags_r)) & ~$past(flagClrData) & 15'h7FFE) == '0;
	endproperty
	a_keep: assert property (p_keep) else $error("other flag disturbed");
endmodule

// ### rtl/mia_prio_pick.sv
// fixed-priority picker with one elevated maskable source
`timescale 1ns/100ps
module mia_prio_pick
	import mia_pkg::*;
#(
	parameter int N = MIA_NUM_MASK
) (
	input  wire logic [N-1:0] reqIn,
	input  wire logic [3:0]   elevSel,
	output logic              pickValid,
	output logic [3:0]        pickIdx
);
	// scan from lowest priority upward so the lowest index wins
	always_comb begin
		pickValid = 1'b0;
		pickIdx = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (reqIn[i]) begin
				pickValid = 1'b1;
				pickIdx = 4'(i);
			end
		end
		// the elevated source overrides the fixed order
		if ((32'(elevSel) < N) && reqIn[elevSel]) begin
			pickValid = 1'b1;
			pickIdx = elevSel;
		end
	end
endmodule
